// >>> hbf_crc16.sv
// Reflected 16-bit frame checksum, W bits per update, lsb first.
// Assumes init and en are never needed in the same cycle.
`timescale 1ns/100ps

module hbf_crc16 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init,
    input wire logic en,
    input wire logic [W-1:0] din,
    output logic [15:0] crc,
    output logic [15:0] crc_next
);

    logic fb;

    always_comb begin
        fb = 1'b0;
        crc_next = crc;
        for (int i = 0; i < W; i++) begin
            fb = crc_next[0] ^ din[i];
            crc_next = {1'b0, crc_next[15:1]}
                ^ (fb ? hbf_pkg::CRC_POLY : 16'h0000);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= hbf_pkg::CRC_INIT;
        end else if (init) begin
            crc <= hbf_pkg::CRC_INIT;
        end else if (en) begin
            crc <= crc_next;
        end
    end

endmodule // hbf_crc16

// >>> hbf_framer.sv
// Byte framer top: host register port, transmit and receive framing.
// Assumes the line bit stream runs at one bit per BIT_DIV clocks,
// with received bits aligned to the same bit tick.
`timescale 1ns/100ps

module hbf_framer #(
    parameter int BIT_DIV = hbf_pkg::BIT_CYCLES
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic RX_DATA,
    output logic TX_DATA,
    output logic IRQ
);

    localparam int DW = $clog2(BIT_DIV + 1);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [DW-1:0] div_cnt_reg;
    logic tick;
    logic [7:0] host_control_reg;
    logic [15:0] buffer_control_word;
    logic framer_en;
    logic tx_tick;
    logic wr_data;
    logic rd_data;
    logic [7:0] hold_reg;
    logic hold_full_reg;
    logic tx_byte_ready_flag;
    logic rx_byte_ready_flag;
    logic tx_ready_irq_enable;
    logic rx_ready_irq_enable;
    logic parallel_data_select;
    hbf_pkg::hbf_tx_state_t tx_state_reg;
    logic [7:0] tx_sh_reg;
    logic [2:0] tx_cnt_reg;
    logic [2:0] tx_ones_reg;
    logic tx_frame_end_flag;
    logic tx_in_content;
    logic tx_stuff;
    logic tx_byte_end;
    logic load_hold;
    logic tx_crc_init;
    logic tx_crc_en;
    logic [15:0] tx_crc;
    logic [15:0] tx_crc_next;
    logic rx_bit;
    logic rx_tick;
    logic rx_in_frame_reg;
    logic rx_got_byte_reg;
    logic [7:0] rx_sh_reg;
    logic [2:0] rx_cnt_reg;
    logic [2:0] rx_ones_reg;
    logic [2:0] rx_ones_inc;
    logic rx_flag;
    logic rx_abort;
    logic rx_stuff;
    logic rx_shift;
    logic rx_byte_done;
    logic [7:0] rx_shift_val;
    logic rx_frame_end;
    logic rx_abort_rep;
    logic rx_good;
    logic rx_deliver;
    logic [7:0] rx_deliv_byte;
    logic rx_deliv_eof;
    logic rx_deliv_fault;
    logic [7:0] rx_buf_reg;
    logic rx_eof_reg;
    logic rx_frame_fault_flag;
    logic [15:0] rx_crc;
    logic [7:0] host_status_reg;
    logic [7:0] framing_status_reg;

    // ------------------------------------------------------------
    // Bit tick
    // ------------------------------------------------------------
    assign tick = (div_cnt_reg == DW'(BIT_DIV - 1));

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            div_cnt_reg <= '0;
        end else if (tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + DW'(1);
        end
    end

    // ------------------------------------------------------------
    // Host registers
    // ------------------------------------------------------------
    assign wr_data = WR && (ADDR == hbf_pkg::OFF_DATA);
    assign rd_data = RD && (ADDR == hbf_pkg::OFF_DATA);
    assign tx_ready_irq_enable = host_control_reg[hbf_pkg::CTRL_TX_READY_IRQ_ENABLE];
    assign rx_ready_irq_enable = host_control_reg[hbf_pkg::CTRL_RX_READY_IRQ_ENABLE];
    assign parallel_data_select = host_control_reg[hbf_pkg::CTRL_PDS];
    // Framing runs only in parallel mode; reset clears both enables
    assign framer_en = buffer_control_word[hbf_pkg::BUF_HDLC]
        && parallel_data_select;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            host_control_reg <= hbf_pkg::CTRL_RST;
            buffer_control_word <= hbf_pkg::BUF_RST;
        end else if (WR) begin
            if (ADDR == hbf_pkg::OFF_CTRL) begin
                host_control_reg <= WDATA[7:0];
            end
            if (ADDR == hbf_pkg::OFF_BUFFER_CONTROL_WORD) begin
                buffer_control_word <= WDATA;
            end
        end
    end

    always_comb begin
        host_status_reg = 8'h00;
        host_status_reg[hbf_pkg::STAT_TXRDY] = tx_byte_ready_flag;
        host_status_reg[hbf_pkg::STAT_RXRDY] = rx_byte_ready_flag;
        framing_status_reg = 8'h00;
        framing_status_reg[hbf_pkg::FST_TX_FRAME_END_FLAG] = tx_frame_end_flag;
        framing_status_reg[hbf_pkg::FST_EOF] = rx_eof_reg;
        framing_status_reg[hbf_pkg::FST_FAULT] = rx_frame_fault_flag;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            unique case (ADDR)
                hbf_pkg::OFF_DATA: RDATA <= {8'h00, rx_buf_reg};
                hbf_pkg::OFF_CTRL: RDATA <= {8'h00, host_control_reg};
                hbf_pkg::OFF_STAT: RDATA <= {8'h00, host_status_reg};
                hbf_pkg::OFF_FSTAT: RDATA <= {8'h00, framing_status_reg};
                hbf_pkg::OFF_BUFFER_CONTROL_WORD: RDATA <= buffer_control_word;
                default: RDATA <= 16'h0000;
            endcase
        end
    end

    // Level interrupt; it drops as soon as the host services the flag
    assign IRQ = (tx_ready_irq_enable && tx_byte_ready_flag)
        || (rx_ready_irq_enable && rx_byte_ready_flag);

    // ------------------------------------------------------------
    // Transmit holding byte
    // ------------------------------------------------------------
    assign tx_byte_ready_flag = framer_en && !hold_full_reg;

    // A write in the cycle the shifter takes the byte refills the holder
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            hold_reg <= 8'h00;
            hold_full_reg <= 1'b0;
        end else if (wr_data && framer_en) begin
            hold_reg <= WDATA[7:0];
            hold_full_reg <= 1'b1;
        end else if (load_hold || !framer_en) begin
            hold_full_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Transmit shifter
    // ------------------------------------------------------------
    assign tx_tick = tick && framer_en;
    assign tx_in_content = (tx_state_reg == hbf_pkg::TXS_BYTE)
        || (tx_state_reg == hbf_pkg::TXS_CRC_LO)
        || (tx_state_reg == hbf_pkg::TXS_CRC_HI);
    // Five ones at the end of the checksum still need their zero
    assign tx_stuff = (tx_in_content || (tx_cnt_reg == 3'h0
        && tx_state_reg == hbf_pkg::TXS_CLOSE))
        && (tx_ones_reg == hbf_pkg::STUFF_RUN);
    assign tx_byte_end = tx_tick && !tx_stuff && (tx_cnt_reg == 3'h7);
    assign load_hold = tx_byte_end && hold_full_reg
        && (tx_state_reg == hbf_pkg::TXS_FLAG
        || tx_state_reg == hbf_pkg::TXS_CLOSE
        || tx_state_reg == hbf_pkg::TXS_BYTE);
    assign tx_crc_init = load_hold
        && (tx_state_reg != hbf_pkg::TXS_BYTE);
    assign tx_crc_en = tx_tick && !tx_stuff
        && (tx_state_reg == hbf_pkg::TXS_BYTE);

    hbf_crc16 #(
        .W(1)
    ) u_tx_crc (
        .clk(MCLK),
        .rst_n(RST_N),
        .init(tx_crc_init),
        .en(tx_crc_en),
        .din(tx_sh_reg[0]),
        .crc(tx_crc),
        .crc_next(tx_crc_next)
    );

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_DATA <= 1'b1;
            tx_ones_reg <= 3'h0;
        end else if (!framer_en) begin
            TX_DATA <= 1'b1;
            tx_ones_reg <= 3'h0;
        end else if (tx_tick && tx_stuff) begin
            TX_DATA <= 1'b0;
            tx_ones_reg <= 3'h0;
        end else if (tx_tick) begin
            TX_DATA <= tx_sh_reg[0];
            if (tx_in_content && tx_sh_reg[0]) begin
                tx_ones_reg <= tx_ones_reg + 3'h1;
            end else begin
                tx_ones_reg <= 3'h0;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_state_reg <= hbf_pkg::TXS_FLAG;
            tx_sh_reg <= hbf_pkg::FLAG_BYTE;
            tx_cnt_reg <= 3'h0;
        end else if (!framer_en) begin
            tx_state_reg <= hbf_pkg::TXS_FLAG;
            tx_sh_reg <= hbf_pkg::FLAG_BYTE;
            tx_cnt_reg <= 3'h0;
        end else if (tx_byte_end) begin
            tx_cnt_reg <= 3'h0;
            unique case (tx_state_reg)
                hbf_pkg::TXS_FLAG, hbf_pkg::TXS_CLOSE: begin
                    if (hold_full_reg) begin
                        tx_sh_reg <= hold_reg;
                        tx_state_reg <= hbf_pkg::TXS_BYTE;
                    end else begin
                        tx_sh_reg <= hbf_pkg::FLAG_BYTE;
                        tx_state_reg <= hbf_pkg::TXS_FLAG;
                    end
                end
                hbf_pkg::TXS_BYTE: begin
                    if (hold_full_reg) begin
                        tx_sh_reg <= hold_reg;
                    end else begin
                        // Next value already holds this byte's last bit
                        tx_sh_reg <= ~tx_crc_next[7:0];
                        tx_state_reg <= hbf_pkg::TXS_CRC_LO;
                    end
                end
                hbf_pkg::TXS_CRC_LO: begin
                    tx_sh_reg <= ~tx_crc[15:8];
                    tx_state_reg <= hbf_pkg::TXS_CRC_HI;
                end
                hbf_pkg::TXS_CRC_HI: begin
                    tx_sh_reg <= hbf_pkg::FLAG_BYTE;
                    tx_state_reg <= hbf_pkg::TXS_CLOSE;
                end
            endcase
        end else if (tx_tick && !tx_stuff) begin
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
        end
    end

    // The closing decision falls at the end of a byte whose loading set
    // the ready flag, so at least eight bit times lie in between
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_frame_end_flag <= 1'b0;
        end else if (!framer_en) begin
            tx_frame_end_flag <= 1'b0;
        end else if (tx_byte_end && !hold_full_reg
            && tx_state_reg == hbf_pkg::TXS_BYTE) begin
            tx_frame_end_flag <= 1'b1;
        end else if (tx_byte_end && tx_state_reg == hbf_pkg::TXS_CRC_HI) begin
            tx_frame_end_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Receive bit classification
    // ------------------------------------------------------------
    hbf_sync2 u_rx_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .d(RX_DATA),
        .q(rx_bit)
    );

    assign rx_tick = tick && framer_en;

    always_comb begin
        rx_ones_inc = (rx_ones_reg == hbf_pkg::ABORT_RUN)
            ? hbf_pkg::ABORT_RUN : rx_ones_reg + 3'h1;
        rx_abort = rx_tick && rx_bit
            && (rx_ones_reg == hbf_pkg::FLAG_RUN);
        rx_flag = rx_tick && !rx_bit
            && (rx_ones_reg == hbf_pkg::FLAG_RUN);
        rx_stuff = rx_tick && !rx_bit
            && (rx_ones_reg == hbf_pkg::STUFF_RUN);
        if (rx_bit) begin
            rx_shift = rx_tick && rx_in_frame_reg
                && (rx_ones_inc < hbf_pkg::FLAG_RUN);
        end else begin
            rx_shift = rx_tick && rx_in_frame_reg && !rx_flag && !rx_stuff;
        end
        rx_shift_val = {rx_bit, rx_sh_reg[7:1]};
        rx_byte_done = rx_shift && (rx_cnt_reg == 3'h7);
        rx_frame_end = rx_flag && rx_in_frame_reg && rx_got_byte_reg;
        rx_abort_rep = rx_abort && rx_in_frame_reg && rx_got_byte_reg;
        // Flag start bits sit in the shifter when the frame closes aligned
        rx_good = (rx_cnt_reg == hbf_pkg::END_BITS)
            && (rx_crc == hbf_pkg::CRC_GOOD);
        rx_deliver = rx_byte_done || rx_frame_end || rx_abort_rep;
        rx_deliv_byte = rx_shift_val;
        rx_deliv_eof = 1'b0;
        rx_deliv_fault = 1'b0;
        if (rx_abort_rep) begin
            rx_deliv_byte = hbf_pkg::ABORT_CODE;
            rx_deliv_fault = 1'b1;
        end else if (rx_frame_end && rx_good) begin
            rx_deliv_byte = hbf_pkg::FLAG_BYTE;
            rx_deliv_eof = 1'b1;
        end else if (rx_frame_end) begin
            rx_deliv_byte = hbf_pkg::BADCRC_CODE;
            rx_deliv_fault = 1'b1;
        end
    end

    hbf_crc16 #(
        .W(8)
    ) u_rx_crc (
        .clk(MCLK),
        .rst_n(RST_N),
        .init(rx_flag),
        .en(rx_byte_done),
        .din(rx_shift_val),
        .crc(rx_crc),
        .crc_next()
    );

    // ------------------------------------------------------------
    // Receive framing state
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_ones_reg <= 3'h0;
            rx_in_frame_reg <= 1'b0;
            rx_got_byte_reg <= 1'b0;
            rx_cnt_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
        end else if (!framer_en) begin
            rx_ones_reg <= 3'h0;
            rx_in_frame_reg <= 1'b0;
            rx_got_byte_reg <= 1'b0;
            rx_cnt_reg <= 3'h0;
        end else if (rx_tick) begin
            rx_ones_reg <= rx_bit ? rx_ones_inc : 3'h0;
            if (rx_flag) begin
                // Any flag opens a frame, so a shared flag works
                rx_in_frame_reg <= 1'b1;
                rx_got_byte_reg <= 1'b0;
                rx_cnt_reg <= 3'h0;
            end else if (rx_abort) begin
                rx_in_frame_reg <= 1'b0;
                rx_got_byte_reg <= 1'b0;
            end else if (rx_shift) begin
                rx_sh_reg <= rx_shift_val;
                rx_cnt_reg <= rx_cnt_reg + 3'h1;
                if (rx_byte_done) begin
                    rx_got_byte_reg <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Receive byte hand-off to host
    // ------------------------------------------------------------
    // No buffering: a byte left unread is overwritten by the next one
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_buf_reg <= 8'h00;
            rx_eof_reg <= 1'b0;
            rx_frame_fault_flag <= 1'b0;
        end else if (rx_deliver) begin
            rx_buf_reg <= rx_deliv_byte;
            rx_eof_reg <= rx_deliv_eof;
            rx_frame_fault_flag <= rx_deliv_fault;
        end
    end

    // A byte arriving in the cycle of the data read keeps the flag set
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_byte_ready_flag <= 1'b0;
        end else if (rx_deliver) begin
            rx_byte_ready_flag <= 1'b1;
        end else if (rd_data) begin
            rx_byte_ready_flag <= 1'b0;
        end
    end

endmodule // hbf_framer

// >>> hbf_framer_assertions.sv
// Port checker for the byte framer top.
// Assumes hbf_pkg is compiled first; bound to every hbf_framer.
`timescale 1ns/100ps

module hbf_framer_assertions #(
    parameter int BIT_DIV = 8
) (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [15:0] RDATA,
    input wire logic TX_DATA,
    input wire logic IRQ
);
    // ----------------
    // Helper state
    // ----------------
    int cnt_reg;
    logic quiet_reg;
    logic [7:0] ctrl_reg;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // Mirrors the bit tick phase, counted from reset release
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_reg <= 0;
            quiet_reg <= 1'b1;
            ctrl_reg <= 8'h00;
        end else begin
            cnt_reg <= (cnt_reg == BIT_DIV - 1) ? 0 : cnt_reg + 1;
            quiet_reg <= quiet_reg & ~WR;
            if (WR && ADDR == hbf_pkg::OFF_CTRL) begin
                ctrl_reg <= WDATA[7:0];
            end
        end
    end
    sequence s_pair(b);
        RD && ADDR == hbf_pkg::OFF_FSTAT ##1 RDATA[b]
            ##1 RD && ADDR == hbf_pkg::OFF_DATA;
    endsequence
    sequence s_stat;
        RD && ADDR == hbf_pkg::OFF_STAT;
    endsequence
    AST_IDLE_UNTIL_SETUP:
        assert property (quiet_reg |-> TX_DATA) else $error("line moved");
    AST_TX_ON_TICK:
        assert property ($changed(TX_DATA) |-> $past(cnt_reg) == BIT_DIV-1)
        else $error("line bit off tick");
    AST_RDATA_HOLDS:
        assert property (!RD |=> $stable(RDATA)) else $error("rdata moved");
    AST_IRQ_TX:
        assert property (s_stat ##1 (ctrl_reg[7] && RDATA[7]) |-> IRQ)
        else $error("tx irq missing");
    AST_IRQ_RX:
        assert property (s_stat ##1 (ctrl_reg[6] && RDATA[6]) |-> IRQ)
        else $error("rx irq missing");
    AST_FAULT_CAUSE:
        assert property (s_pair(0) |=> RDATA[7:0] inside
            {hbf_pkg::ABORT_CODE, hbf_pkg::BADCRC_CODE})
        else $error("bad fault code");
    AST_EOF_BYTE:
        assert property (s_pair(1) |=> RDATA[7:0] == hbf_pkg::FLAG_BYTE)
        else $error("bad end byte");
    AST_EOF_FAULT_APART:
        assert property (RD && ADDR == hbf_pkg::OFF_FSTAT
            |=> !(RDATA[1] && RDATA[0])) else $error("eof with fault");
endmodule // hbf_framer_assertions

bind hbf_framer hbf_framer_assertions #(.BIT_DIV(BIT_DIV)) u_chk (
    .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .TX_DATA(TX_DATA), .IRQ(IRQ));

// >>> hbf_host_model.sv
// Host model: register port master and per-byte frame handling.
// Assumes a slave that samples strobes on rising clk, never waits.
`timescale 1ns/100ps

module hbf_host_model (
    input wire logic clk,
    output logic [3:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [15:0] rdata
);
    // ----------------
    // Bus cycles
    // ----------------
    logic [7:0] rx_q[$];
    logic [2:0] st_q[$];
    logic saw_end;
    initial begin
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    // Called just after a rising edge; leaves an idle cycle after
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask
    task automatic setup(input logic [7:0] ctrl);
        logic [15:0] v;
        wr_reg(hbf_pkg::OFF_CTRL, {8'h00, ctrl});
        wr_reg(hbf_pkg::OFF_BUFFER_CONTROL_WORD, 16'h0080);
        rd_reg(hbf_pkg::OFF_DATA, v);
    endtask
    // One poll pass is far shorter than a byte time, so no byte is lost
    task automatic xfer(input logic [7:0] tx[$]);
        logic [15:0] s;
        logic [15:0] f;
        logic [15:0] v;
        logic done;
        int i;
        i = 0;
        done = 1'b0;
        rx_q = {};
        st_q = {};
        saw_end = 1'b0;
        for (int k = 0; k < 3000 && !done; k++) begin
            rd_reg(hbf_pkg::OFF_STAT, s);
            rd_reg(hbf_pkg::OFF_FSTAT, f);
            saw_end = saw_end | f[2];
            if (s[6]) begin
                rd_reg(hbf_pkg::OFF_DATA, v);
                rx_q.push_back(v[7:0]);
                st_q.push_back(f[2:0]);
                done = |f[1:0];
            end
            if (s[7] && i < tx.size()) begin
                wr_reg(hbf_pkg::OFF_DATA, {8'h00, tx[i]});
                i++;
            end
        end
    endtask
endmodule // hbf_host_model

// >>> hbf_pkg.sv
// Constants, offsets and types shared by the byte framer files.
// Assumes one 100 MHz clock and a host on a plain strobe port.
// Overview of operation
// - Frame is flag, data, two checksums, flag.
// - Flag symbol is byte 7e.
// - Receiver treats over six ones as abort.
// - Transmitter sends flags while no frame is pending.
// - Transmitter inserts zero after five ones.
// - Receiver deletes zero following five ones.
// - Sixteen bit checksum over unstuffed frame content.
// - Checksum bytes follow last data, then flag.
// - One flag may close and open frames.
// - Framer off after reset, needs parallel select.
// - Ready flag set; host writes bytes in order.
// - Transmit ready raises interrupt when enabled.
// - No byte supplied: close frame, set end flag.
// - End flag waits eight bits after ready.
// - End flag clears at closing flag start.
// - Receive ready per byte, interrupt when enabled.
// - Both status bits clear means data byte.
// - Good frame sets end bit; checksums precede.
// - Failed frame sets fault; host discards bytes.
// - Fault byte ff means abort, 7e bad checksum.

package hbf_pkg;

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFF_DATA = 4'h0;
    localparam logic [3:0] OFF_CTRL = 4'h4;
    localparam logic [3:0] OFF_STAT = 4'h5;
    localparam logic [3:0] OFF_FSTAT = 4'h7;
    localparam logic [3:0] OFF_BUFFER_CONTROL_WORD = 4'h8;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_TX_READY_IRQ_ENABLE = 7;
    localparam int CTRL_RX_READY_IRQ_ENABLE = 6;
    localparam int CTRL_PDS = 4;
    localparam int STAT_TXRDY = 7;
    localparam int STAT_RXRDY = 6;
    localparam int FST_TX_FRAME_END_FLAG = 2;
    localparam int FST_EOF = 1;
    localparam int FST_FAULT = 0;
    localparam int BUF_HDLC = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] BUF_RST = 16'h0000;

    // ------------------------------------------------------------
    // Framing symbols and checksum
    // ------------------------------------------------------------
    localparam logic [7:0] FLAG_BYTE = 8'h7e;
    localparam logic [7:0] ABORT_CODE = 8'hff;
    localparam logic [7:0] BADCRC_CODE = 8'h7e;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_GOOD = 16'hf0b8;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] FLAG_RUN = 3'h6;
    localparam logic [2:0] ABORT_RUN = 3'h7;
    localparam logic [2:0] END_BITS = 3'h6;

    // ------------------------------------------------------------
    // Bit timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100000000;
    localparam int BIT_BPS = 2400;
    localparam int BIT_CYCLES = CLK_HZ / BIT_BPS;

    typedef enum logic [2:0] {
        TXS_FLAG,
        TXS_BYTE,
        TXS_CRC_LO,
        TXS_CRC_HI,
        TXS_CLOSE
    } hbf_tx_state_t;

endpackage

// >>> hbf_sync2.sv
// Two flip-flop synchroniser for one asynchronous level.
// Assumes the level is slow against the clock.
`timescale 1ns/100ps

module hbf_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic d,
    output logic q
);

    logic meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            q <= 1'b1;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule // hbf_sync2

// >>> tb_top.sv
// Self-checking bench for the byte framer with the line looped back.
// Assumes package, design, host model and checker compiled first.
`timescale 1ns/100ps

module tb_top;
    // ----------------
    // Clock, line, instances
    // ----------------
    localparam int DIV = 8;
    logic MCLK;
    logic RST_N;
    logic cut_mode;
    logic cut;
    logic rx_line;
    logic tx_line;
    logic irq;
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic [15:0] d;
    logic [7:0] q[$];
    logic [3:0] amap[6] = '{4'h0, 4'h4, 4'h5, 4'h7, 4'h8, 4'h3};
    int n_errors;
    int tests_run;
    int cycles;
    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end
    // Cut forces a run of ones after the first received byte
    assign rx_line = cut ? 1'b1 : tx_line;
    always @(posedge MCLK) begin
        cut <= cut_mode && u_host.rx_q.size() != 0;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    hbf_framer #(.BIT_DIV(DIV)) u_hbf_framer (.MCLK(MCLK), .RST_N(RST_N),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .RX_DATA(rx_line), .TX_DATA(tx_line), .IRQ(irq));
    hbf_host_model u_host (.clk(MCLK), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    // ----------------
    // Checking tasks
    // ----------------
    task automatic chk(input string what, input logic [15:0] e,
        input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    function automatic logic [15:0] fcs(input logic [7:0] b[$]);
        logic [15:0] c;
        c = hbf_pkg::CRC_INIT;
        foreach (b[i]) begin
            for (int j = 0; j < 8; j++) begin
                c = (c[0] ^ b[i][j]) ? (c >> 1) ^ hbf_pkg::CRC_POLY : c >> 1;
            end
        end
        return ~c;
    endfunction
    task automatic frame(input logic [7:0] tx[$]);
        logic [15:0] c;
        logic [2:0] s;
        int n;
        c = fcs(tx);
        q = tx;
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        q.push_back(hbf_pkg::FLAG_BYTE);
        u_host.xfer(tx);
        n = u_host.rx_q.size();
        chk("rx count", 16'(q.size()), 16'(n));
        chk("tx end seen", 16'h0001, {15'h0000, u_host.saw_end});
        for (int i = 0; i < n && i < q.size(); i++) begin
            chk("rx byte", {8'h00, q[i]}, {8'h00, u_host.rx_q[i]});
            s = u_host.st_q[i];
            if (i < n - 1) begin
                s[2] = 1'b0;
            end
            chk("rx status", (i == n - 1) ? 16'h0002 : 16'h0000,
                {13'h0000, s});
        end
    endtask
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        RST_N = 1'b0;
        cut_mode = 1'b0;
        cut = 1'b0;
        cycles = 0;
        n_errors = 0;
        tests_run = 0;
        repeat (16) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        for (int i = 0; i < 6; i++) begin
            u_host.rd_reg(amap[i], d);
            chk("reset read", 16'h0000, d);
        end
        chk("idle line", 16'h0001, {15'h0000, tx_line});
        u_host.wr_reg(hbf_pkg::OFF_BUFFER_CONTROL_WORD, 16'h0080);
        u_host.rd_reg(hbf_pkg::OFF_STAT, d);
        chk("no parallel select", 16'h0000, d);
        $display("test reset done");
        u_host.setup(8'hd0);
        u_host.rd_reg(hbf_pkg::OFF_STAT, d);
        chk("tx ready", 16'h0080, d);
        chk("tx irq", 16'h0001, {15'h0000, irq});
        q = {8'h7e, 8'hff, 8'h3c};
        frame(q);
        q = {8'hf8};
        frame(q);
        $display("test frames done");
        cut_mode = 1'b1;
        q = {8'h11, 8'h22, 8'h33};
        u_host.xfer(q);
        chk("abort first", 16'h0011, {8'h00, u_host.rx_q[0]});
        chk("abort code", 16'h00ff, {8'h00, u_host.rx_q[$]});
        chk("abort status", 16'h0001, {14'h0000, u_host.st_q[$][1:0]});
        u_host.wr_reg(hbf_pkg::OFF_CTRL, 16'h0010);
        chk("irq masked", 16'h0000, {15'h0000, irq});
        $display("test abort done");
        results();
    end
endmodule // tb_top
